// *** src/bao_pkg.sv ***
package bao_pkg;

   // Operation codes presented by the CPU sequencer
   typedef enum logic [3:0] {
      BAO_OP_BIT_LOAD     = 4'h0,
      BAO_OP_BIT_STORE    = 4'h1,
      BAO_OP_FORCE_ONE    = 4'h2,
      BAO_OP_FORCE_ZERO   = 4'h3,
      BAO_OP_BR_LOW       = 4'h4,
      BAO_OP_BR_HIGH      = 4'h5,
      BAO_OP_TEST_MARK    = 4'h6,
      BAO_OP_STALL_HIGH   = 4'h7,
      BAO_OP_STALL_LOW    = 4'h8,
      BAO_OP_BYTE_SWAP    = 4'h9,
      BAO_OP_HALF_EXCH    = 4'ha,
      BAO_OP_BYTE_SIGN    = 4'hb,
      BAO_OP_BYTE_CLEAR   = 4'hc,
      BAO_OP_WORD_CLEAR   = 4'hd,
      BAO_OP_WORD_SIGN    = 4'he
   } bao_op_e;

   // Addressing form of a bit operand
   typedef enum logic [1:0] {
      BAO_AM_DIRECT = 2'h0,
      BAO_AM_ABS16  = 2'h1,
      BAO_AM_IO     = 2'h2
   } bao_am_e;

   // Instruction lengths in bytes
   localparam logic [2:0] BAO_LEN_SHORT = 3'h3;
   localparam logic [2:0] BAO_LEN_LONG = 3'h4;
   localparam logic [2:0] BAO_LEN_BR_SHORT = 3'h4;
   localparam logic [2:0] BAO_LEN_BR_LONG = 3'h5;
   localparam logic [2:0] BAO_LEN_ACC = 3'h1;

   // Cycle counts; accumulator ops take one cycle more than their entry
   localparam logic [2:0] BAO_CYC_LOAD = 3'h3;
   localparam logic [2:0] BAO_CYC_RMW = 3'h4;
   localparam logic [2:0] BAO_CYC_BR_TAKEN = 3'h5;
   localparam logic [2:0] BAO_CYC_BR_NOT = 3'h4;
   localparam logic [2:0] BAO_CYC_TM_TAKEN = 3'h7;
   localparam logic [2:0] BAO_CYC_TM_NOT = 3'h6;
   localparam logic [2:0] BAO_CYC_BYTE_SWAP = 3'h3;
   localparam logic [2:0] BAO_CYC_WORD = 3'h2;
   localparam logic [2:0] BAO_CYC_BYTE = 3'h1;

   // Reset values
   localparam logic [31:0] BAO_ACC_RST = 32'h0000_0000;
   localparam logic [23:0] BAO_ADDR_RST = 24'h00_0000;

   // Request from the CPU sequencer
   typedef struct packed {
      bao_op_e op;
      bao_am_e am;
      logic [23:0] addr;
      logic [2:0] bit_pos;
      logic [31:0] acc;
      logic neg;
      logic zero;
   } bao_req_s;

   // Result back to the CPU sequencer
   typedef struct packed {
      logic [31:0] acc;
      logic neg;
      logic zero;
      logic flags_wr;
      logic acc_wr;
      logic branch;
      logic [2:0] length;
   } bao_rsp_s;

   // Internal memory and I/O bus request
   typedef struct packed {
      logic rd;
      logic wr;
      logic io;
      logic [23:0] addr;
      logic [7:0] wdata;
   } bao_bus_s;

endpackage

// *** src/bao_core.sv ***
`timescale 1ns/10ps
// How it works
// - Bit load puts bit in low byte, clears rest of low half; N,Z follow.
// - Bit store rewrites containing byte in 4 cycles; N,Z updated.
// - Branch-if-bit-low branches when bit is 0; Z from tested bit.
// - Branch-if-bit-high branches when bit is 1; Z from tested bit.
// - Bit branches take 5 cycles taken, 4 not taken.
// - Test-then-mark branches on 1 and sets bit by read-modify-write.
// - Test-then-mark takes 7 cycles taken, 6 otherwise.
// - Stall-until-high polls the I/O bit until it reads 1.
// - Stall-until-low polls the I/O bit until 0, flags unchanged.
// - Byte swap exchanges the two low accumulator bytes in 4 cycles, flags kept.
// - Half exchange swaps 16-bit halves in 3 cycles, flags kept.
// - Byte sign fill copies bit 7 into bits 8-15 in 2 cycles; N,Z.
// - Byte clear fill zeroes bits 8-15 in 2 cycles; N cleared, Z from low byte.
// - Word clear fill zeroes upper half in 3 cycles; N cleared, Z.
// - Word sign fill copies bit 15 to upper half in 3 cycles; N,Z.
module bao_core
   import bao_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // CPU sequencer side
   input wire logic start_i,
   input wire bao_req_s req_i,
   output logic busy_o,
   output logic done_o,
   output bao_rsp_s rsp_o,
   // Memory and I/O bus side
   output bao_bus_s bus_o,
   input wire logic [7:0] bus_rdata_i
);

   // Execution states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_READ  = 6'b000010,
      ST_WRITE = 6'b000100,
      ST_POLL  = 6'b001000,
      ST_WAIT  = 6'b010000,
      ST_DONE  = 6'b100000
   } bao_st_e;

   // Instruction length from operation and addressing
   function automatic logic [2:0] len_of(input bao_op_e op,
                                         input bao_am_e am);
      logic lng;
      lng = (am == BAO_AM_ABS16);
      case (op)
         BAO_OP_BR_LOW, BAO_OP_BR_HIGH:
            len_of = lng ? BAO_LEN_BR_LONG : BAO_LEN_BR_SHORT;
         BAO_OP_TEST_MARK: len_of = BAO_LEN_BR_LONG;
         BAO_OP_BYTE_SWAP, BAO_OP_HALF_EXCH, BAO_OP_BYTE_SIGN,
         BAO_OP_BYTE_CLEAR, BAO_OP_WORD_CLEAR, BAO_OP_WORD_SIGN:
            len_of = BAO_LEN_ACC;
         default: len_of = lng ? BAO_LEN_LONG : BAO_LEN_SHORT;
      endcase
   endfunction

   // Byte with one bit replaced
   function automatic logic [7:0] put_bit(input logic [7:0] b,
                                          input logic [2:0] pos,
                                          input logic v);
      logic [7:0] r;
      r = b;
      r[pos] = v;
      put_bit = r;
   endfunction

   // Held request, result, bus request and cycle count
   bao_st_e st_r, st_nxt;
   bao_req_s req_r, req_nxt;
   bao_rsp_s rsp_r, rsp_nxt;
   bao_bus_s bus_r, bus_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [7:0] io_s1_r, io_s2_r;
   logic [7:0] rd_byte;
   logic tbit;

   // I/O bits change outside our control; polled value is synchronised
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         io_s1_r <= 8'h00;
         io_s2_r <= 8'h00;
      end else begin
         io_s1_r <= bus_rdata_i;
         io_s2_r <= io_s1_r;
      end
   end

   // Bit under test straight from the read byte
   assign rd_byte = bus_rdata_i;
   assign tbit = rd_byte[req_r.bit_pos];

   // Next state and datapath
   always_comb begin
      st_nxt = st_r;
      req_nxt = req_r;
      rsp_nxt = rsp_r;
      bus_nxt = bus_r;
      cnt_nxt = cnt_r;
      bus_nxt.rd = 1'b0;
      bus_nxt.wr = 1'b0;
      case (st_r)
         ST_IDLE: begin
            // Result strobes drop once back in idle
            rsp_nxt.flags_wr = 1'b0;
            rsp_nxt.acc_wr = 1'b0;
            rsp_nxt.branch = 1'b0;
            if (start_i) begin
               // Capture the request; bus ops open with a read
               req_nxt = req_i;
               rsp_nxt.acc = req_i.acc;
               rsp_nxt.neg = req_i.neg;
               rsp_nxt.zero = req_i.zero;
               rsp_nxt.length = len_of(req_i.op, req_i.am);
               bus_nxt.addr = req_i.addr;
               bus_nxt.io = (req_i.am == BAO_AM_IO);
               cnt_nxt = 3'h1;
               // Accumulator ops go straight to the pad count
               case (req_i.op)
                  BAO_OP_BYTE_SWAP: begin
                     rsp_nxt.acc[15:0] =
                        {req_i.acc[7:0], req_i.acc[15:8]};
                     rsp_nxt.acc_wr = 1'b1;
                     cnt_nxt = BAO_CYC_BYTE_SWAP;
                     st_nxt = ST_WAIT;
                  end
                  BAO_OP_HALF_EXCH: begin
                     rsp_nxt.acc =
                        {req_i.acc[15:0], req_i.acc[31:16]};
                     rsp_nxt.acc_wr = 1'b1;
                     cnt_nxt = BAO_CYC_WORD;
                     st_nxt = ST_WAIT;
                  end
                  BAO_OP_BYTE_SIGN: begin
                     rsp_nxt.acc[15:8] = {8{req_i.acc[7]}};
                     rsp_nxt.neg = req_i.acc[7];
                     rsp_nxt.zero = (req_i.acc[7:0] == 8'h00);
                     rsp_nxt.acc_wr = 1'b1;
                     rsp_nxt.flags_wr = 1'b1;
                     cnt_nxt = BAO_CYC_BYTE;
                     st_nxt = ST_WAIT;
                  end
                  BAO_OP_BYTE_CLEAR: begin
                     rsp_nxt.acc[15:8] = 8'h00;
                     rsp_nxt.neg = 1'b0;
                     rsp_nxt.zero = (req_i.acc[7:0] == 8'h00);
                     rsp_nxt.acc_wr = 1'b1;
                     rsp_nxt.flags_wr = 1'b1;
                     cnt_nxt = BAO_CYC_BYTE;
                     st_nxt = ST_WAIT;
                  end
                  BAO_OP_WORD_CLEAR: begin
                     rsp_nxt.acc[31:16] = 16'h0000;
                     rsp_nxt.neg = 1'b0;
                     rsp_nxt.zero = (req_i.acc[15:0] == 16'h0000);
                     rsp_nxt.acc_wr = 1'b1;
                     rsp_nxt.flags_wr = 1'b1;
                     cnt_nxt = BAO_CYC_WORD;
                     st_nxt = ST_WAIT;
                  end
                  BAO_OP_WORD_SIGN: begin
                     rsp_nxt.acc[31:16] = {16{req_i.acc[15]}};
                     rsp_nxt.neg = req_i.acc[15];
                     rsp_nxt.zero = (req_i.acc[15:0] == 16'h0000);
                     rsp_nxt.acc_wr = 1'b1;
                     rsp_nxt.flags_wr = 1'b1;
                     cnt_nxt = BAO_CYC_WORD;
                     st_nxt = ST_WAIT;
                  end
                  BAO_OP_STALL_HIGH, BAO_OP_STALL_LOW: begin
                     bus_nxt.rd = 1'b1;
                     st_nxt = ST_POLL;
                  end
                  default: begin
                     bus_nxt.rd = 1'b1;
                     st_nxt = ST_READ;
                  end
               endcase
            end
         end
         ST_READ: begin
            // Read byte stands in this cycle only
            cnt_nxt = cnt_r + 3'h1;
            bus_nxt.wdata = rd_byte;
            case (req_r.op)
               BAO_OP_BIT_LOAD: begin
                  rsp_nxt.acc[15:0] = {15'h0000, tbit};
                  rsp_nxt.neg = 1'b0;
                  rsp_nxt.zero = ~tbit;
                  rsp_nxt.acc_wr = 1'b1;
                  rsp_nxt.flags_wr = 1'b1;
                  st_nxt = ST_WAIT;
                  cnt_nxt = BAO_CYC_LOAD - 3'h2;
               end
               BAO_OP_BIT_STORE: begin
                  bus_nxt.wdata = put_bit(rd_byte, req_r.bit_pos,
                                          req_r.acc[0]);
                  rsp_nxt.neg = 1'b0;
                  rsp_nxt.zero = ~req_r.acc[0];
                  rsp_nxt.flags_wr = 1'b1;
                  bus_nxt.wr = 1'b1;
                  st_nxt = ST_WRITE;
               end
               BAO_OP_FORCE_ONE: begin
                  bus_nxt.wdata = put_bit(rd_byte, req_r.bit_pos,
                                          1'b1);
                  bus_nxt.wr = 1'b1;
                  st_nxt = ST_WRITE;
               end
               BAO_OP_FORCE_ZERO: begin
                  bus_nxt.wdata = put_bit(rd_byte, req_r.bit_pos,
                                          1'b0);
                  bus_nxt.wr = 1'b1;
                  st_nxt = ST_WRITE;
               end
               BAO_OP_BR_LOW, BAO_OP_BR_HIGH: begin
                  rsp_nxt.zero = ~tbit;
                  rsp_nxt.flags_wr = 1'b1;
                  rsp_nxt.branch = (req_r.op == BAO_OP_BR_HIGH) ?
                     tbit : ~tbit;
                  cnt_nxt = (rsp_nxt.branch ? BAO_CYC_BR_TAKEN :
                     BAO_CYC_BR_NOT) - 3'h2;
                  st_nxt = ST_WAIT;
               end
               BAO_OP_TEST_MARK: begin
                  rsp_nxt.zero = ~tbit;
                  rsp_nxt.flags_wr = 1'b1;
                  rsp_nxt.branch = tbit;
                  bus_nxt.wdata = put_bit(rd_byte, req_r.bit_pos, 1'b1);
                  bus_nxt.wr = 1'b1;
                  st_nxt = ST_WRITE;
               end
               default: st_nxt = ST_DONE;
            endcase
         end
         ST_WRITE: begin
            // Byte written; count the remaining cycles
            if (req_r.op == BAO_OP_TEST_MARK) begin
               cnt_nxt = (rsp_r.branch ? BAO_CYC_TM_TAKEN :
                  BAO_CYC_TM_NOT) - 3'h3;
            end else begin
               cnt_nxt = BAO_CYC_RMW - 3'h3;
            end
            st_nxt = ST_WAIT;
         end
         ST_POLL: begin
            // Sync stages must fill from this read before a check
            if (cnt_r < 3'h3) begin
               cnt_nxt = cnt_r + 3'h1;
               bus_nxt.rd = 1'b1;
            end else if ((req_r.op == BAO_OP_STALL_HIGH) &&
                io_s2_r[req_r.bit_pos]) begin
               st_nxt = ST_DONE;
            end else if ((req_r.op == BAO_OP_STALL_LOW) &&
                         !io_s2_r[req_r.bit_pos]) begin
               st_nxt = ST_DONE;
            end else begin
               bus_nxt.rd = 1'b1;
            end
         end
         ST_WAIT: begin
            // Pad out to the instruction's cycle count
            if (cnt_r <= 3'h1) begin
               st_nxt = ST_DONE;
            end else begin
               cnt_nxt = cnt_r - 3'h1;
            end
         end
         // One cycle of done, then idle
         ST_DONE: st_nxt = ST_IDLE;
         default: st_nxt = ST_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r <= ST_IDLE;
         req_r <= '0;
         rsp_r <= '0;
         bus_r <= '0;
         cnt_r <= 3'h0;
      end else begin
         st_r <= st_nxt;
         req_r <= req_nxt;
         rsp_r <= rsp_nxt;
         bus_r <= bus_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Outputs straight from registers
   assign busy_o = (st_r != ST_IDLE);
   assign done_o = (st_r == ST_DONE);
   assign rsp_o = rsp_r;
   assign bus_o = bus_r;

endmodule

// *** test/bao_core_checker.sv ***
`timescale 1ns/10ps
module bao_core_checker
   import bao_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Sequencer side
   input wire logic start_i,
   input wire bao_req_s req_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire bao_rsp_s rsp_o,
   // Bus side
   input wire bao_bus_s bus_o,
   input wire logic [7:0] bus_rdata_i
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   logic go;
   bao_op_e op;
   assign go = start_i && !busy_o;
   assign op = req_i.op;
   load_time_a: assert property (go && op == BAO_OP_BIT_LOAD |-> ##3 done_o)
      else $error("bit load done late");
   rmw_time_a: assert property (go && (op == BAO_OP_BIT_STORE ||
      op == BAO_OP_FORCE_ONE || op == BAO_OP_FORCE_ZERO) |-> ##4 done_o)
      else $error("bit rewrite done late");
   branch_time_a: assert property (go && (op == BAO_OP_BR_LOW ||
      op == BAO_OP_BR_HIGH) |-> ##4 ((done_o && !rsp_o.branch) or
      (!done_o ##1 (done_o && rsp_o.branch))))
      else $error("bit branch timing wrong");
   mark_time_a: assert property (go && op == BAO_OP_TEST_MARK |->
      ##6 ((done_o && !rsp_o.branch) or
      (!done_o ##1 (done_o && rsp_o.branch))))
      else $error("test mark timing wrong");
   byte_swap_a: assert property (go && op == BAO_OP_BYTE_SWAP |-> ##4 (done_o
      && !rsp_o.flags_wr && rsp_o.acc[15:0] ==
      {$past(req_i.acc[7:0], 4), $past(req_i.acc[15:8], 4)}))
      else $error("byte swap wrong");
   half_exch_a: assert property (go && op == BAO_OP_HALF_EXCH |-> ##3 (done_o
      && !rsp_o.flags_wr && rsp_o.acc ==
      {$past(req_i.acc[15:0], 3), $past(req_i.acc[31:16], 3)}))
      else $error("half exchange wrong");
   sign_fill_a: assert property (go && op == BAO_OP_BYTE_SIGN |-> ##2 (done_o
      && rsp_o.acc[15:8] == {8{$past(req_i.acc[7], 2)}}
      && rsp_o.neg == $past(req_i.acc[7], 2)))
      else $error("byte sign fill wrong");
   clear_fill_a: assert property (go && op == BAO_OP_BYTE_CLEAR |-> ##2 (done_o
      && rsp_o.acc[15:8] == 8'h00 && !rsp_o.neg))
      else $error("byte clear fill wrong");
   word_fill_a: assert property (go && (op == BAO_OP_WORD_CLEAR ||
      op == BAO_OP_WORD_SIGN) |-> ##3 (done_o && rsp_o.acc[31:16] ==
      {16{$past(req_i.acc[15], 3) && $past(req_i.op, 3) == BAO_OP_WORD_SIGN}}))
      else $error("word fill wrong");
   write_pulse_a: assert property (bus_o.wr |=> !bus_o.wr)
      else $error("bus write longer than one cycle");
   done_pulse_a: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
endmodule

bind bao_core bao_core_checker u_chk (.clk_sys_i(clk_sys_i),
   .arst_n_i(arst_n_i), .start_i(start_i), .req_i(req_i), .busy_o(busy_o),
   .done_o(done_o), .rsp_o(rsp_o), .bus_o(bus_o), .bus_rdata_i(bus_rdata_i));

// *** test/bao_mem_model.sv ***
`timescale 1ns/10ps
module bao_mem_model
   import bao_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Bus
   input wire bao_bus_s bus_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [256];
   logic [7:0] a_r;
   logic [7:0] last_r;
   logic v_r;
   // Released data line shows inverse of last value
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         v_r <= 1'b0;
         last_r <= 8'h00;
      end else begin
         v_r <= bus_i.rd;
         last_r <= rdata_o;
         if (bus_i.rd) a_r <= bus_i.addr[7:0];
         if (bus_i.wr) mem[bus_i.addr[7:0]] <= bus_i.wdata;
      end
   end
   always_comb begin
      if (bus_i.rd) rdata_o = mem[bus_i.addr[7:0]];
      else if (v_r) rdata_o = mem[a_r];
      else rdata_o = ~last_r;
   end
endmodule

// *** test/bit_and_accumulator_ops_tb_top.sv ***
`timescale 1ns/10ps
module bit_and_accumulator_ops_tb_top;
   import bao_pkg::*;
   logic clk_sys_i = 0;
   logic arst_n_i = 0;
   logic start_i = 0;
   bao_req_s req_i = '0;
   logic busy_o, done_o;
   bao_rsp_s rsp_o;
   bao_bus_s bus_o;
   logic [7:0] bus_rdata_i;
   int n_errors = 0;
   int n_compared = 0;
   always #25 clk_sys_i = ~clk_sys_i;
   bao_core u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .start_i(start_i), .req_i(req_i), .busy_o(busy_o), .done_o(done_o),
      .rsp_o(rsp_o), .bus_o(bus_o), .bus_rdata_i(bus_rdata_i));
   bao_mem_model u_mem (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .bus_i(bus_o), .rdata_o(bus_rdata_i));
   task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic test_done();
      if (n_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      int o, a, b, cyc, lo, hi;
      logic [31:0] acc, e;
      logic [7:0] m;
      logic bt, en, ez, fw, br;
      int am, ln;
      logic aw;
      logic [1:0] fl;
      void'($urandom(68798));
      repeat (4) @(negedge clk_sys_i);
      arst_n_i = 1;
      for (int i = 0; i < 60; i++) begin
         o = i % 15;
         a = $urandom_range(255);
         b = $urandom_range(7);
         acc = $urandom;
         u_mem.mem[a] = 8'($urandom);
         if (o == 7) u_mem.mem[a][b] = 1'b0;
         if (o == 8) u_mem.mem[a][b] = 1'b1;
         bt = u_mem.mem[a][b];
         m = u_mem.mem[a];
         e = acc;
         fl = 2'($urandom);
         am = $urandom_range(2);
         {en, ez, fw, br} = {fl, 2'b10};
         case (o)
            0: begin e[15:0] = {15'h0, bt}; en = 0; ez = !bt; lo = 3; end
            1: begin m[b] = acc[0]; en = 0; ez = !acc[0]; lo = 4; end
            2: begin m[b] = 1'b1; fw = 0; lo = 4; end
            3: begin m[b] = 1'b0; fw = 0; lo = 4; end
            4: begin br = !bt; ez = !bt; lo = br ? 5 : 4; end
            5: begin br = bt; ez = !bt; lo = br ? 5 : 4; end
            6: begin br = bt; ez = !bt; m[b] = 1'b1; lo = bt ? 7 : 6; end
            7, 8: begin m[b] = ~bt; fw = 0; lo = 6; end
            9: begin e[15:0] = {acc[7:0], acc[15:8]}; fw = 0; lo = 4; end
            10: begin e = {acc[15:0], acc[31:16]}; fw = 0; lo = 3; end
            11: begin e[15:8] = {8{acc[7]}}; en = acc[7]; lo = 2; end
            12: begin e[15:8] = 8'h00; en = 0; lo = 2; end
            13: begin e[31:16] = 16'h0; en = 0; lo = 3; end
            default: begin e[31:16] = {16{acc[15]}}; en = acc[15]; lo = 3; end
         endcase
         if (o == 11 || o == 12) ez = e[15:0] == 0;
         if (o > 12) ez = e == 0;
         hi = (o == 7 || o == 8) ? 40 : lo;
         aw = (o == 0 || o > 8);
         ln = (o > 8) ? 1 : (o == 6) ? 5 : ((o > 3) ? 4 : 3) + (am == 1);
         @(negedge clk_sys_i);
         req_i = {bao_op_e'(o), bao_am_e'(am), 24'(a), 3'(b), acc, fl};
         start_i = 1;
         for (cyc = 1; cyc <= 40; cyc++) begin
            @(negedge clk_sys_i);
            start_i = 0;
            if (cyc == 5 && (o == 7 || o == 8)) u_mem.mem[a][b] = ~bt;
            if (done_o === 1'b1) break;
         end
         if (cyc > 40) begin
            n_errors++;
            test_done();
         end
         chk(32'(cyc >= lo && cyc <= hi), 1, "cycle count");
         chk(rsp_o.flags_wr, fw, "flag write");
         chk(u_mem.mem[a], m, "memory byte");
         chk(rsp_o.acc, e, "accumulator");
         chk(rsp_o.neg, en, "negative flag");
         chk(rsp_o.zero, ez, "zero flag");
         if (o > 3 && o < 7) chk(rsp_o.branch, br, "branch");
         chk(rsp_o.acc_wr, aw, "acc write");
         if (o < 7 || o > 8) chk(rsp_o.length, ln, "length");
      end
      test_done();
   end
endmodule
